// >>> ifd_decoder.sv
// instruction word decoder and cycle timing sequencer
`timescale 1ns/1ns
// =====================================================
// =====================================================
// timing walk of one instruction cycle
// phase 0 edge: the word latched at the previous phase 3 edge is split into fields
// phase 1 edge: the file read strobe is raised for byte and bit words in the exec state
// phase 2 edge: file read data is captured into the read buffer
// phase 3 edge: the result is stored, the next word is fetched, the state moves on
// all four steps happen inside one instruction cycle, so the rate is a quarter of the clock
// =====================================================
// sequencer states
// exec: the word in the instruction register runs normally
// flush: the word in the instruction register was fetched behind a flow change;
//     it is decoded so that the field outputs stay meaningful, but no store or
//     accumulator update is allowed, and the squash flag tells the outside so
// indwait: the dead cycle that follows an indirect access whose pointer
//     addresses program memory; the word already fetched is held, not replaced,
//     and no new word is fetched, so the program loses nothing to the stall
// =====================================================
// notes for users of this block
// the file read strobe is raised even for words that only write the file; this
//     keeps the read, modify, write order uniform and lets peripherals with
//     read side effects see the same pattern for every file operand
// the skip on count words tests the live read data at phase 3, so the file side
//     must hold its read data from phase 2 through the end of phase 3
// the bit skip tests the buffered data, which stays correct as long as the file
//     side answers a read strobe within the same phase
// an indirect stall takes precedence over a flush: a taken skip whose file is an
//     indirect register meets both, and its skip is then lost
// the program memory side need not keep its word stable across the dead cycle,
//     because the fetch strobe stays low there and the word was already taken before it
// among literal words, the accumulator is loaded only by the literal move and the literal return;
//     the relative jump shares the upper opcode bits and must not touch it
// the write strobe and write data leave the block together after phase 3,
//     so a file side clocked on the same edge sees both in one cycle
// =====================================================
// trade-offs
// the decode happens one clock after the fetch rather than at the fetch edge;
//     this costs nothing because the first file access is only at phase 1,
//     and it keeps the fetch path free of the wide class decoder
// all state lives in one packed record so that reset and hold are uniform
// the class codes are coarse: they carry timing, not the full operation, which
//     the execution side decodes again from the literal and address fields
// =====================================================
// limitations
// only two pointer pairs are known, at the two lowest file addresses
// the pointer update itself is left to the data side; this block only reports
//     the selected pointer and its update mode
// the stack and the program counter are outside this block; a call or return
//     is seen here only as a two cycle timing class
// =====================================================
module ifd_decoder (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // instruction word from program memory
    input wire logic [ifd_pkg::INSN_W-1:0] I_INSN,
    // data read from the file register named by the operand
    input wire logic [ifd_pkg::DATA_W-1:0] I_FILE_RDATA,
    // pointer values of both pointer pairs
    input wire logic [ifd_pkg::PC_W:0] I_PTR0,
    input wire logic [ifd_pkg::PC_W:0] I_PTR1,
    // instruction cycle phase and fetch control
    output logic [1:0] O_PHASE,
    output logic O_ICYC,
    output logic O_FETCH,
    // decoded fields
    output logic [1:0] O_GROUP,
    output logic [3:0] O_CLASS,
    output logic [ifd_pkg::FADDR_W-1:0] O_FADDR,
    output logic [ifd_pkg::BIT_W-1:0] O_BITSEL,
    output logic [ifd_pkg::KLIT_W-1:0] O_LITERAL,
    output logic O_DEST_FILE,
    output logic O_PTR_SEL,
    output logic [1:0] O_PTR_MODE,
    // file register access strobes
    output logic O_FILE_RD,
    output logic O_FILE_WR,
    output logic [ifd_pkg::DATA_W-1:0] O_FILE_WDATA,
    // accumulator and squash status
    output logic [ifd_pkg::DATA_W-1:0] O_ACC,
    output logic O_SQUASH
);
    import ifd_pkg::*;

    typedef struct packed {
        logic [1:0] phase;
        ifd_state_t st;
        logic [INSN_W-1:0] ir;
        logic icyc;
        logic fetch;
        logic [1:0] grp;
        logic [3:0] cls;
        logic [FADDR_W-1:0] faddr;
        logic [BIT_W-1:0] bitsel;
        logic [KLIT_W-1:0] lit;
        logic dest;
        logic psel;
        logic [1:0] pmode;
        logic frd;
        logic fwr;
        logic [DATA_W-1:0] fwdata;
        logic [DATA_W-1:0] acc;
        logic squash;
        logic [DATA_W-1:0] rbuf;
    } ifd_s_t;

    ifd_s_t s_r;
    ifd_s_t s_nxt;

    // group from the top two opcode bits; 00 byte, 01 bit, 1x literal
    function automatic logic [1:0] grp_of(input logic [INSN_W-1:0] w);
        if (w[13:12] == 2'h0) begin
            return GRP_BYTE;
        end else if (w[13:12] == 2'h1) begin
            return GRP_BIT;
        end
        return GRP_LIT;
    endfunction

    // timing class of a word
    function automatic logic [3:0] cls_of(input logic [INSN_W-1:0] w);
        if (w[13:11] == 3'b100) begin
            return CL_CALL;
        end else if (w[13:11] == 3'b101 || w[13:9] == 5'b11001) begin
            return CL_JUMP;
        end else if (w[13:10] == 4'b0110 || w[13:10] == 4'b0111) begin
            return CL_SKIP_BIT;
        end else if (w[13:8] == 6'h0B || w[13:8] == 6'h0F) begin
            return CL_SKIP_CNT;
        end else if (w == 14'h000A || w == 14'h000B) begin
            return w[0] ? CL_JUMP : CL_CALL;
        end else if (w == 14'h0008 || w == 14'h0009 || w[13:10] == 4'b1101) begin
            return CL_RET;
        end else if (w[13:3] == 11'h002) begin
            return CL_PTR_MOVE;
        end
        return CL_PLAIN;
    endfunction

    // byte operation result; opcode bits 11 to 8 pick the function
    function automatic logic [DATA_W-1:0] alu(input logic [3:0] op, input logic [DATA_W-1:0] f,
            input logic [DATA_W-1:0] w);
        unique case (op)
            4'h1: return 8'h00;
            4'h2: return f - w;
            4'h3: return f - 8'h01;
            4'h4: return f | w;
            4'h5: return f & w;
            4'h6: return f ^ w;
            4'h7: return f + w;
            4'h8: return f;
            4'h9: return ~f;
            4'hA: return f + 8'h01;
            4'hB: return f - 8'h01;
            4'hE: return {f[3:0], f[7:4]};
            4'hF: return f + 8'h01;
            default: return f;
        endcase
    endfunction

    logic [DATA_W-1:0] res;
    logic ind_prog;
    logic taken;

    // next-state logic, evaluated once per oscillator clock
    always_comb begin
        s_nxt = s_r;
        s_nxt.fetch = 1'b0;
        s_nxt.icyc = 1'b0;
        s_nxt.frd = 1'b0;
        s_nxt.fwr = 1'b0;
        res = alu(s_r.ir[11:8], I_FILE_RDATA, s_r.acc);
        ind_prog = (s_r.faddr == INDIR0_ADDR && I_PTR0[PTR_PROG_BIT])
            || (s_r.faddr == INDIR1_ADDR && I_PTR1[PTR_PROG_BIT]);
        taken = 1'b0;
        // four oscillator clocks make one instruction cycle
        s_nxt.phase = s_r.phase + 2'h1;
        unique case (s_r.phase)
            2'h0: begin
                // decode the word latched at the end of the last cycle
                s_nxt.grp = grp_of(s_r.ir);
                s_nxt.cls = cls_of(s_r.ir);
                s_nxt.faddr = s_r.ir[6:0];
                s_nxt.bitsel = s_r.ir[9:7];
                s_nxt.lit = s_r.ir[10:0];
                s_nxt.dest = s_r.ir[7];
                s_nxt.psel = s_r.ir[2];
                s_nxt.pmode = s_r.ir[1:0];
                s_nxt.squash = (s_r.st == ST_FLUSH);
            end
            2'h1: begin
                // in the exec state, read the file operand first, even for pure writes
                s_nxt.frd = (s_r.st == ST_EXEC) && (s_r.grp != GRP_LIT);
            end
            2'h2: begin
                s_nxt.rbuf = I_FILE_RDATA;
            end
            2'h3: begin
                s_nxt.icyc = 1'b1;
                // the dead indirect cycle keeps the word already fetched
                if (s_r.st != ST_INDWAIT) begin
                    s_nxt.fetch = 1'b1;
                    s_nxt.ir = I_INSN;
                end
                if (s_r.st == ST_EXEC) begin
                    // modify and store; accumulator is the implicit partner
                    if (s_r.grp == GRP_BYTE && s_r.cls != CL_PTR_MOVE && s_r.ir[11:8] != 4'h0) begin
                        if (s_r.dest) begin
                            s_nxt.fwr = 1'b1;
                            s_nxt.fwdata = alu(s_r.ir[11:8], s_r.rbuf, s_r.acc);
                        end else begin
                            s_nxt.acc = alu(s_r.ir[11:8], s_r.rbuf, s_r.acc);
                        end
                    end else if (s_r.ir[13:10] == 4'b0100 || s_r.ir[13:10] == 4'b0101) begin
                        s_nxt.fwr = 1'b1;
                        s_nxt.fwdata = s_r.rbuf;
                        s_nxt.fwdata[s_r.bitsel] = s_r.ir[10];
                    end else if (s_r.ir[13:7] == 7'h01) begin
                        s_nxt.fwr = 1'b1;
                        s_nxt.fwdata = s_r.acc;
                    end else if (s_r.ir[13:9] == 5'b11000 || s_r.ir[13:10] == 4'b1101) begin
                        s_nxt.acc = s_r.lit[7:0];
                    end
                    // skip taken only on the tested condition
                    if (s_r.cls == CL_SKIP_BIT) begin
                        taken = s_r.rbuf[s_r.bitsel] == s_r.ir[10];
                    end else if (s_r.cls == CL_SKIP_CNT) begin
                        taken = res == 8'h00;
                    end
                    if (s_r.grp != GRP_LIT && ind_prog) begin
                        s_nxt.st = ST_INDWAIT;
                    end else if (s_r.cls inside {CL_CALL, CL_RET, CL_JUMP} || taken) begin
                        s_nxt.st = ST_FLUSH;
                    end else begin
                        s_nxt.st = ST_EXEC;
                    end
                end else begin
                    // the word fetched behind a flow change is dropped
                    s_nxt.st = ST_EXEC;
                end
            end
            default: begin
                s_nxt.phase = 2'h0;
            end
        endcase
        // while flushing, no architectural write may occur
        if (s_r.st == ST_FLUSH && s_r.phase == OSC_PER_ICYC_LAST) begin
            s_nxt.fwr = 1'b0;
            s_nxt.acc = s_r.acc;
        end
    end

    // state register
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            s_r <= '0;
            s_r.st <= ST_EXEC;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    assign O_PHASE = s_r.phase;
    assign O_ICYC = s_r.icyc;
    assign O_FETCH = s_r.fetch;
    assign O_GROUP = s_r.grp;
    assign O_CLASS = s_r.cls;
    assign O_FADDR = s_r.faddr;
    assign O_BITSEL = s_r.bitsel;
    assign O_LITERAL = s_r.lit;
    assign O_DEST_FILE = s_r.dest;
    assign O_PTR_SEL = s_r.psel;
    assign O_PTR_MODE = s_r.pmode;
    assign O_FILE_RD = s_r.frd;
    assign O_FILE_WR = s_r.fwr;
    assign O_FILE_WDATA = s_r.fwdata;
    assign O_ACC = s_r.acc;
    assign O_SQUASH = s_r.squash;
endmodule

// >>> ifd_pkg.sv
// package of constants and types for the instruction decode and timing block
package ifd_pkg;
    // =====================================================
    // word and field geometry
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int BIT_W = 3;
    localparam int KLIT_W = 11;
    localparam int PC_W = 15;
    // =====================================================
    // timing: last oscillator clock of the instruction cycle; pointer update modes
    localparam logic [1:0] OSC_PER_ICYC_LAST = 2'h3;
    localparam logic [1:0] MM_PREINC = 2'h0;
    localparam logic [1:0] MM_PREDEC = 2'h1;
    localparam logic [1:0] MM_POSTINC = 2'h2;
    localparam logic [1:0] MM_POSTDEC = 2'h3;
    // indirect access register addresses and program memory window in pointer space
    localparam logic [6:0] INDIR0_ADDR = 7'h00;
    localparam logic [6:0] INDIR1_ADDR = 7'h01;
    localparam int PTR_PROG_BIT = 15;
    // =====================================================
    // instruction group and class
    typedef enum logic [1:0] {
        GRP_BYTE = 2'h0,
        GRP_BIT = 2'h1,
        GRP_LIT = 2'h2
    } ifd_grp_t;
    typedef enum logic [3:0] {
        CL_PLAIN = 4'h0,
        CL_CALL = 4'h1,
        CL_RET = 4'h2,
        CL_JUMP = 4'h3,
        CL_SKIP_BIT = 4'h4,
        CL_SKIP_CNT = 4'h5,
        CL_PTR_MOVE = 4'h6
    } ifd_cls_t;
    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_EXEC = 3'b001,
        ST_FLUSH = 3'b010,
        ST_INDWAIT = 3'b100
    } ifd_state_t;
endpackage

// >>> ifd_decoder_sva.sv
// port-level assertions for the instruction decoder
`timescale 1ns/1ns
// =====================================================
// checker
module ifd_decoder_sva (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // watched outputs
    input wire logic [1:0] O_PHASE,
    input wire logic O_ICYC,
    input wire logic O_FETCH,
    input wire logic [1:0] O_GROUP,
    input wire logic O_FILE_RD,
    input wire logic [10:0] O_LITERAL,
    input wire logic [6:0] O_FADDR,
    input wire logic [2:0] O_BITSEL,
    input wire logic O_DEST_FILE,
    input wire logic O_PTR_SEL,
    input wire logic [1:0] O_PTR_MODE
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    phase_wrap_a: assert property (O_PHASE == 2'h3 |=> O_PHASE == 2'h0)
        else $error("phase did not wrap");
    icyc_period_a: assert property (O_ICYC |=> !O_ICYC [*3] ##1 O_ICYC)
        else $error("cycle pulse not every four clocks");
    icyc_phase_a: assert property (O_ICYC |-> O_PHASE == 2'h0)
        else $error("cycle pulse off phase zero");
    fetch_pair_a: assert property (O_FETCH |-> O_ICYC)
        else $error("fetch without cycle pulse");
    read_phase_a: assert property (O_FILE_RD |-> O_PHASE == 2'h2)
        else $error("file read off phase two");
    lit_noread_a: assert property (O_FILE_RD |-> O_GROUP != 2'h2)
        else $error("literal group read a file");
    group_legal_a: assert property (O_GROUP != 2'h3)
        else $error("illegal group code");
    addr_bit_a: assert property (O_FADDR == O_LITERAL[6:0] && O_BITSEL == O_LITERAL[9:7])
        else $error("address or bit field misplaced");
    dest_ptr_a: assert property (O_DEST_FILE == O_LITERAL[7] && {O_PTR_SEL, O_PTR_MODE} == O_LITERAL[2:0])
        else $error("destination or pointer field misplaced");
    fields_hold_a: assert property (O_PHASE == 2'h3 |-> $stable(O_LITERAL) && $stable(O_GROUP))
        else $error("fields moved inside a cycle");
endmodule

bind ifd_decoder ifd_decoder_sva u_sva (
    .I_CLK(I_CLK), .I_RESET(I_RESET), .O_PHASE(O_PHASE), .O_ICYC(O_ICYC), .O_FETCH(O_FETCH),
    .O_GROUP(O_GROUP), .O_FILE_RD(O_FILE_RD), .O_LITERAL(O_LITERAL), .O_FADDR(O_FADDR),
    .O_BITSEL(O_BITSEL), .O_DEST_FILE(O_DEST_FILE), .O_PTR_SEL(O_PTR_SEL), .O_PTR_MODE(O_PTR_MODE)
);

// >>> ifd_mem_model.sv
// behavioural file register model answering the decoder's read strobes
`timescale 1ns/1ns
// =====================================================
// file register model
module ifd_mem_model (
    // clock and strobes
    input wire logic i_clk,
    input wire logic [1:0] i_phase,
    input wire logic i_file_rd,
    input wire logic [6:0] i_faddr,
    // read data
    output logic [7:0] o_rdata
);
    initial o_rdata = 8'h00;
    // each register reads back its address; the bus holds it through phase 3 and is inverted in phase 0 when not read
    always @(negedge i_clk) begin
        if (i_file_rd) begin
            o_rdata <= {1'b0, i_faddr};
        end else if (i_phase == 2'h0) begin
            o_rdata <= ~o_rdata;
        end
    end
endmodule

// >>> test_instruction_format_and_timing.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
// =====================================================
// bench
module test_instruction_format_and_timing;
    import ifd_pkg::*;
    logic I_CLK = 1'b0;
    logic I_RESET = 1'b1;
    logic [13:0] I_INSN = 14'h0000;
    logic [7:0] I_FILE_RDATA;
    logic [15:0] I_PTR0 = 16'h0000;
    logic [15:0] I_PTR1 = 16'h0000;
    logic [1:0] O_PHASE, O_GROUP, O_PTR_MODE;
    logic [3:0] O_CLASS;
    logic [6:0] O_FADDR;
    logic [2:0] O_BITSEL;
    logic [10:0] O_LITERAL;
    logic [7:0] O_FILE_WDATA, O_ACC;
    logic O_ICYC, O_FETCH, O_DEST_FILE, O_PTR_SEL, O_FILE_RD, O_FILE_WR, O_SQUASH;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    int n_fetch = 0;
    logic [31:0] seed = 32'hEBAB;
    // calls, returns, jumps, taken and untaken skips, pointer move, plain words
    logic [13:0] corner [18] = '{14'h2123, 14'h000A, 14'h0008, 14'h0009, 14'h345A, 14'h2ABC,
        14'h3305, 14'h000B, 14'h1885, 14'h1805, 14'h1C05, 14'h0B81, 14'h0B85, 14'h0FFF,
        14'h0013, 14'h3080, 14'h0742, 14'h3FFF};
    ifd_decoder dut (
        .I_CLK(I_CLK), .I_RESET(I_RESET), .I_INSN(I_INSN), .I_FILE_RDATA(I_FILE_RDATA),
        .I_PTR0(I_PTR0), .I_PTR1(I_PTR1), .O_PHASE(O_PHASE), .O_ICYC(O_ICYC), .O_FETCH(O_FETCH),
        .O_GROUP(O_GROUP), .O_CLASS(O_CLASS), .O_FADDR(O_FADDR), .O_BITSEL(O_BITSEL),
        .O_LITERAL(O_LITERAL), .O_DEST_FILE(O_DEST_FILE), .O_PTR_SEL(O_PTR_SEL),
        .O_PTR_MODE(O_PTR_MODE), .O_FILE_RD(O_FILE_RD), .O_FILE_WR(O_FILE_WR),
        .O_FILE_WDATA(O_FILE_WDATA), .O_ACC(O_ACC), .O_SQUASH(O_SQUASH)
    );
    ifd_mem_model u_mem (
        .i_clk(I_CLK), .i_phase(O_PHASE), .i_file_rd(O_FILE_RD), .i_faddr(O_FADDR), .o_rdata(I_FILE_RDATA)
    );
    // free-running clock
    always #5 I_CLK = ~I_CLK;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // class from the top opcode bits, mirroring the common 14-bit layout
    function automatic logic [3:0] exp_cls(input logic [13:0] w);
        if (w[13:11] == 3'h4 || w == 14'h000A) return 4'h1;
        if (w[13:11] == 3'h5 || w[13:9] == 5'h19 || w == 14'h000B) return 4'h3;
        if (w[13:10] == 4'hD || w == 14'h0008 || w == 14'h0009) return 4'h2;
        if (w[13:11] == 3'h3) return 4'h4;
        if (w[13:8] == 6'h0B || w[13:8] == 6'h0F) return 4'h5;
        if (w[13:3] == 11'h002) return 4'h6;
        return 4'h0;
    endfunction
    // the model's file data equals the address, so skip outcomes follow from the word alone
    function automatic logic exp_flush(input logic [13:0] w);
        logic [7:0] f;
        f = {1'b0, w[6:0]};
        case (exp_cls(w))
            4'h1, 4'h2, 4'h3: return 1'b1;
            4'h4: return f[w[9:7]] == w[10];
            4'h5: return (w[10] ? f + 8'h01 : f - 8'h01) == 8'h00;
            default: return 1'b0;
        endcase
    endfunction
    task automatic wait_phase(input logic [1:0] p);
        int n;
        n = 0;
        @(negedge I_CLK);
        while (O_PHASE !== p && n < 8) begin
            @(negedge I_CLK);
            n++;
        end
    endtask
    // one word followed by a nop, whose cycle shows whether it was discarded
    task automatic run_word(input logic [13:0] w);
        wait_phase(2'h3);
        I_INSN = w;
        wait_phase(2'h2);
        `CHK("group", (w[13] ? 2'h2 : {1'b0, w[12]}), O_GROUP)
        `CHK("class", exp_cls(w), O_CLASS)
        `CHK("literal", w[10:0], O_LITERAL)
        if (w[13:12] != 2'h0) `CHK("file read", !w[13], O_FILE_RD)
        wait_phase(2'h3);
        I_INSN = 14'h0000;
        wait_phase(2'h2);
        `CHK("squash", exp_flush(w), O_SQUASH)
        if (w[13:9] == 5'h18 || w[13:10] == 4'hD) `CHK("acc", w[7:0], O_ACC)
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // hang guard, far above the fewer than 700 clocks the run needs
    always @(posedge I_CLK) begin
        cycles++;
        if (cycles == 8000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // main sequence; pointers keep bit 15 clear outside the indirect step, so no indirect dead cycle shifts the walk
    initial begin
        repeat (16) @(negedge I_CLK);
        I_RESET = 1'b0;
        foreach (corner[i]) run_word(corner[i]);
        $display("test corner done");
        // indirect read through pointer 0 into program memory costs one dead cycle
        I_PTR0 = 16'h8000;
        wait_phase(2'h3);
        I_INSN = 14'h0800;
        @(negedge I_CLK);
        I_INSN = 14'h0000;
        repeat (11) begin
            @(negedge I_CLK);
            n_fetch += O_FETCH;
        end
        `CHK("indirect fetches", 1, n_fetch)
        I_PTR0 = 16'h0000;
        $display("test indirect done");
        repeat (60) begin
            seed = xs(seed);
            I_PTR0 = {1'b0, seed[30:16]};
            I_PTR1 = {1'b0, seed[14:0]};
            seed = xs(seed);
            run_word(seed[13:0]);
        end
        $display("test random done");
        print_verdict();
    end
endmodule
